/* mltdc_bank.sv */
// Monitor-level trap and secure debug configuration register bank
`timescale 1ns/100ps
`default_nettype none
module mltdc_bank
  import mltdc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // System register move port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic REG_SEL,
  input wire logic [1:0] CUR_LEVEL,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_DENIED,
  // Trap requests from the pipeline
  input wire logic KERNEL_COPROC_ACCESS,
  input wire logic HYP_TRAP_REG_ACCESS,
  input wire logic HYP_TRAPPED,
  input wire logic FP_ACCESS,
  input wire logic LOWER_FP_TRAPPED,
  input wire logic OS_DEBUG_ACCESS,
  input wire logic DEBUG_REG_ACCESS,
  input wire logic PERFMON_ACCESS,
  output logic TRAP_TO_MONITOR,
  // External debugger and authentication
  input wire logic EXT_PERFMON_REQ,
  input wire logic EXT_BKPT_REQ,
  input wire logic AUTH_OVERRIDE,
  output logic EXT_PERFMON_OK,
  output logic EXT_BKPT_OK,
  // Secure debug state
  input wire logic SECURE_STATE,
  input wire logic KERNEL_64BIT,
  input wire logic KERNEL_DEBUG_ENABLE_FLAG,
  input wire logic DEBUG_MASK_FLAG,
  input wire logic LEGACY_DEBUG_EN,
  input wire logic SW_BREAKPOINT,
  output logic SECURE_COUNT_OK,
  output logic DEBUG_EXC_OK
);

  // ************************************************************************
  // Register storage
  // ************************************************************************
  logic [31:0] trap_reg;
  logic [31:0] dbg_reg;
  logic at_monitor;
  logic [1:0] spd;
  logic cp_access;
  logic next_trap;
  logic next_dbg_ok;

  // Only the monitor level may touch the bank
  assign at_monitor = (CUR_LEVEL == MLTDC_MONITOR); // R12
  assign spd = dbg_reg[MLTDC_SPD_HI:MLTDC_SPD_LO];

  // Writes keep reserved bits at their fixed values
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      trap_reg <= MLTDC_TRAP_RESET; // R2
    else if (REG_WR && at_monitor && REG_SEL == MLTDC_SEL_TRAP) // R12
      trap_reg <= (REG_WDATA & MLTDC_TRAP_WMASK) | MLTDC_TRAP_RES1; // R13
  end

  // Debug configuration, unknown fields start cleared
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      dbg_reg <= MLTDC_DBG_RESET; // R3 R4 R5 R8
    else if (REG_WR && at_monitor && REG_SEL == MLTDC_SEL_DEBUG) // R12
      dbg_reg <= REG_WDATA & MLTDC_DBG_WMASK; // R13
  end

  // Read data registered; denied reads return zero
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      REG_RDATA <= 32'h00000000;
      REG_DENIED <= 1'b0;
    end
    else
    begin
      REG_DENIED <= (REG_RD || REG_WR) && !at_monitor; // R12
      if (REG_RD && at_monitor)
        REG_RDATA <= (REG_SEL == MLTDC_SEL_TRAP) ? trap_reg : dbg_reg;
      else
        REG_RDATA <= 32'h00000000;
    end
  end

  // ************************************************************************
  // Trap decision
  // ************************************************************************
  always_comb
  begin
    cp_access = (KERNEL_COPROC_ACCESS && CUR_LEVEL == MLTDC_KERNEL) ||
                (HYP_TRAP_REG_ACCESS && CUR_LEVEL == MLTDC_HYP);
    next_trap = 1'b0;
    if (trap_reg[MLTDC_CPAC_BIT] && cp_access && !HYP_TRAPPED)
      next_trap = 1'b1; // R1
    if (trap_reg[MLTDC_FP_BIT] && FP_ACCESS && !LOWER_FP_TRAPPED)
      next_trap = 1'b1; // R2
    if (dbg_reg[MLTDC_OSDA_BIT] && OS_DEBUG_ACCESS)
      next_trap = 1'b1; // R9
    if (dbg_reg[MLTDC_DA_BIT] && DEBUG_REG_ACCESS)
      next_trap = 1'b1; // R10
    if (dbg_reg[MLTDC_PM_BIT] && PERFMON_ACCESS)
      next_trap = 1'b1; // R11
  end

  // ************************************************************************
  // Secure debug exception enable
  // ************************************************************************
  // Software breakpoints always pass; the bank never masks them
  always_comb
  begin
    next_dbg_ok = 1'b1;
    if (SECURE_STATE && !SW_BREAKPOINT)
    begin
      if (KERNEL_64BIT)
      begin
        if (dbg_reg[MLTDC_SDD_BIT])
          next_dbg_ok = 1'b0; // R6
        else if (CUR_LEVEL == MLTDC_KERNEL)
          next_dbg_ok = KERNEL_DEBUG_ENABLE_FLAG && !DEBUG_MASK_FLAG; // R7
        else
          next_dbg_ok = (CUR_LEVEL == MLTDC_USER); // R7
      end
      else if (CUR_LEVEL == MLTDC_KERNEL)
      begin
        // Reserved code treated as disabled, the safe reading
        unique case (spd)
          MLTDC_SPD_LEGACY: next_dbg_ok = LEGACY_DEBUG_EN; // R8
          MLTDC_SPD_ENABLE: next_dbg_ok = 1'b1; // R8
          MLTDC_SPD_DISABLE: next_dbg_ok = 1'b0; // R8
          default: next_dbg_ok = 1'b0; // R8
        endcase
      end
    end
  end

  // Registered outputs; all driven from reset
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      TRAP_TO_MONITOR <= 1'b0;
      EXT_PERFMON_OK <= 1'b0;
      EXT_BKPT_OK <= 1'b0;
      SECURE_COUNT_OK <= 1'b0;
      DEBUG_EXC_OK <= 1'b0;
    end
    else
    begin
      TRAP_TO_MONITOR <= next_trap;
      EXT_PERFMON_OK <= EXT_PERFMON_REQ &&
        (!dbg_reg[MLTDC_EXT_PERFMON_ACCESS_DISABLE_BIT] || AUTH_OVERRIDE); // R3
      EXT_BKPT_OK <= EXT_BKPT_REQ &&
        (!dbg_reg[MLTDC_EXT_BREAKPOINT_ACCESS_DISABLE_BIT] || AUTH_OVERRIDE); // R4
      SECURE_COUNT_OK <= !SECURE_STATE || dbg_reg[MLTDC_SECURE_EVENT_COUNT_ENABLE_BIT]; // R5
      DEBUG_EXC_OK <= next_dbg_ok;
    end
  end

  // ************************************************************************
  // Checks
  // ************************************************************************
  chk_lower_write_blocked: assert property ( // R12
    @(posedge CLK) disable iff (SYS_RST)
    (REG_WR && CUR_LEVEL != MLTDC_MONITOR) |=>
      $stable(trap_reg) && $stable(dbg_reg))
    else $error("lower level write changed a register");
  chk_trap_res1_fixed: assert property ( // R13
    @(posedge CLK) disable iff (SYS_RST)
    (trap_reg & ~MLTDC_TRAP_WMASK) == MLTDC_TRAP_RES1)
    else $error("trap register reserved bits wrong");
  chk_fp_trap_out: assert property ( // R2
    @(posedge CLK) disable iff (SYS_RST)
    (trap_reg[MLTDC_FP_BIT] && FP_ACCESS && !LOWER_FP_TRAPPED) |=>
      TRAP_TO_MONITOR)
    else $error("float access not trapped");
  chk_cpac_trap_out: assert property ( // R1
    @(posedge CLK) disable iff (SYS_RST)
    (trap_reg[MLTDC_CPAC_BIT] && KERNEL_COPROC_ACCESS &&
     CUR_LEVEL == MLTDC_KERNEL && !HYP_TRAPPED) |=> TRAP_TO_MONITOR)
    else $error("coprocessor access not trapped");
  chk_debug_trap_out: assert property ( // R10
    @(posedge CLK) disable iff (SYS_RST)
    (dbg_reg[MLTDC_DA_BIT] && DEBUG_REG_ACCESS) |=> TRAP_TO_MONITOR)
    else $error("debug register access not trapped");
  chk_perfmon_ext: assert property ( // R3
    @(posedge CLK) disable iff (SYS_RST)
    (dbg_reg[MLTDC_EXT_PERFMON_ACCESS_DISABLE_BIT] && !AUTH_OVERRIDE) |=> !EXT_PERFMON_OK)
    else $error("external perfmon access not refused");
  chk_secure_count: assert property ( // R5
    @(posedge CLK) disable iff (SYS_RST)
    (SECURE_STATE && !dbg_reg[MLTDC_SECURE_EVENT_COUNT_ENABLE_BIT]) |=> !SECURE_COUNT_OK)
    else $error("secure counting not prohibited");
  chk_sdd_blocks: assert property ( // R6
    @(posedge CLK) disable iff (SYS_RST)
    (SECURE_STATE && KERNEL_64BIT && dbg_reg[MLTDC_SDD_BIT] &&
     !SW_BREAKPOINT) |=> !DEBUG_EXC_OK)
    else $error("secure debug not disabled");
  chk_bkpt_ext: assert property ( // R4
    @(posedge CLK) disable iff (SYS_RST)
    (dbg_reg[MLTDC_EXT_BREAKPOINT_ACCESS_DISABLE_BIT] && !AUTH_OVERRIDE) |=> !EXT_BKPT_OK)
    else $error("external breakpoint access not refused");
  chk_os_debug_trap: assert property ( // R9
    @(posedge CLK) disable iff (SYS_RST)
    (dbg_reg[MLTDC_OSDA_BIT] && OS_DEBUG_ACCESS) |=> TRAP_TO_MONITOR)
    else $error("os debug register access not trapped");
  chk_perfmon_trap: assert property ( // R11
    @(posedge CLK) disable iff (SYS_RST)
    (dbg_reg[MLTDC_PM_BIT] && PERFMON_ACCESS) |=> TRAP_TO_MONITOR)
    else $error("perfmon register access not trapped");
  chk_user_debug_en: assert property ( // R7
    @(posedge CLK) disable iff (SYS_RST)
    (SECURE_STATE && KERNEL_64BIT && !dbg_reg[MLTDC_SDD_BIT] &&
     CUR_LEVEL == MLTDC_USER) |=> DEBUG_EXC_OK)
    else $error("secure user debug not enabled");
  chk_spd_disable: assert property ( // R8
    @(posedge CLK) disable iff (SYS_RST)
    (SECURE_STATE && !KERNEL_64BIT && CUR_LEVEL == MLTDC_KERNEL &&
     !SW_BREAKPOINT && spd == MLTDC_SPD_DISABLE) |=> !DEBUG_EXC_OK)
    else $error("32-bit secure kernel debug not disabled");

endmodule
`default_nettype wire

/* mltdc_bank_bench.sv */
// Self-checking bench for the monitor trap and debug config bank
`timescale 1ns/100ps
`default_nettype none
module mltdc_bank_bench;
  import mltdc_pkg::*;
  // ****************************************************
  // Stimulus, row table and design instance
  // ****************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic [16:0] stim = 17'h0;
  logic [31:0] rdata;
  logic denied;
  logic [4:0] outs;
  int n_mismatch = 0;
  int tests_run = 0;
  // Row: trap bits, debug reg, level, stimulus, expected outputs
  logic [57:0] rows [26] = '{
    {2'h2, 32'h0, 19'b01_10000000_000_000000, 5'b10011},
    {2'h2, 32'h0, 19'b10_01000000_000_000000, 5'b10011},
    {2'h0, 32'h8000, 19'b01_00000000_000_100010, 5'b00000},
    {2'h0, 32'h0, 19'b01_00000000_000_100010, 5'b00001},
    {2'h0, 32'h0, 19'b01_00000000_000_100000, 5'b00000},
    {2'h2, 32'h0, 19'b10_01100000_000_000000, 5'b00011},
    {2'h0, 32'h0, 19'b01_10000000_000_000000, 5'b00011},
    {2'h1, 32'h0, 19'b00_00010000_000_000000, 5'b10011},
    {2'h1, 32'h0, 19'b00_00011000_000_000000, 5'b00011},
    {2'h0, 32'h400, 19'b01_00000100_000_000000, 5'b10011},
    {2'h0, 32'h200, 19'b01_00000010_000_000000, 5'b10011},
    {2'h0, 32'h40, 19'b01_00000001_000_000000, 5'b10011},
    {2'h0, 32'h0, 19'b01_00000001_000_000000, 5'b00011},
    {2'h0, 32'h200000, 19'b00_00000000_100_000000, 5'b00011},
    {2'h0, 32'h200000, 19'b00_00000000_101_000000, 5'b01011},
    {2'h0, 32'h0, 19'b00_00000000_100_000000, 5'b01011},
    {2'h0, 32'h100000, 19'b00_00000000_010_000000, 5'b00011},
    {2'h0, 32'h100000, 19'b00_00000000_011_000000, 5'b00111},
    {2'h0, 32'h0, 19'b00_00000000_000_110000, 5'b00001},
    {2'h0, 32'h20000, 19'b00_00000000_000_110000, 5'b00011},
    {2'h0, 32'h10000, 19'b00_00000000_000_110000, 5'b00000},
    {2'h0, 32'h10000, 19'b01_00000000_000_111001, 5'b00001},
    {2'h0, 32'h0, 19'b01_00000000_000_111000, 5'b00001},
    {2'h0, 32'h0, 19'b01_00000000_000_111100, 5'b00000},
    {2'h0, 32'h4000, 19'b01_00000000_000_100010, 5'b00000},
    {2'h0, 32'hC000, 19'b01_00000000_000_100000, 5'b00001}};
  // Half period of 5 ns gives 100 MHz
  always #5 clk = ~clk;
  mltdc_bank i_mltdc_bank (.CLK(clk), .SYS_RST(rst), .REG_WR(wr),
    .REG_RD(rd), .REG_SEL(sel), .CUR_LEVEL(lvl), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_DENIED(denied),
    .KERNEL_COPROC_ACCESS(stim[16]), .HYP_TRAP_REG_ACCESS(stim[15]),
    .HYP_TRAPPED(stim[14]), .FP_ACCESS(stim[13]),
    .LOWER_FP_TRAPPED(stim[12]), .OS_DEBUG_ACCESS(stim[11]),
    .DEBUG_REG_ACCESS(stim[10]), .PERFMON_ACCESS(stim[9]),
    .TRAP_TO_MONITOR(outs[4]), .EXT_PERFMON_REQ(stim[8]),
    .EXT_BKPT_REQ(stim[7]), .AUTH_OVERRIDE(stim[6]),
    .EXT_PERFMON_OK(outs[3]), .EXT_BKPT_OK(outs[2]),
    .SECURE_STATE(stim[5]), .KERNEL_64BIT(stim[4]),
    .KERNEL_DEBUG_ENABLE_FLAG(stim[3]), .DEBUG_MASK_FLAG(stim[2]),
    .LEGACY_DEBUG_EN(stim[1]), .SW_BREAKPOINT(stim[0]),
    .SECURE_COUNT_OK(outs[1]), .DEBUG_EXC_OK(outs[0]));
  // ****************************************************
  // Compare, bus and verdict tasks
  // ****************************************************
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flags %b, wanted %b", $time, got, exp);
    end
  endtask
  // Refusal flag is looked at in the one cycle it stands
  task automatic reg_wr(input logic s, input logic [1:0] l,
                        input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    lvl <= l;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk_out({4'h0, denied}, {4'h0, l != 2'h3});
  endtask
  task automatic reg_rd(input logic s, input logic [1:0] l,
                        input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    sel <= s;
    lvl <= l;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_data(rdata, exp);
    chk_out({4'h0, denied}, {4'h0, l != 2'h3});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Whole run is a few hundred cycles, so 50 us is ample
  initial
  begin
    #50000;
    n_mismatch++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up();
  end
  // Main sequence: reset, table rows, then the awkward cases
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    chk_out({outs[4:1], denied}, 5'h00);
    @(posedge clk);
    rst <= 1'b0;
    reg_rd(1'b0, 2'h3, 32'h000033FF);
    reg_rd(1'b1, 2'h3, 32'h00000000);
    $display("reset values done");
    foreach (rows[i])
    begin
      reg_wr(1'b0, 2'h3, {rows[i][57], 20'h0, rows[i][56], 10'h0});
      reg_wr(1'b1, 2'h3, rows[i][55:24]);
      @(posedge clk);
      lvl <= rows[i][23:22];
      stim <= rows[i][21:5];
      @(posedge clk);
      stim <= 17'h0;
      #1;
      chk_out(outs, rows[i][4:0]);
    end
    $display("table rows done");
    reg_wr(1'b0, 2'h3, 32'hFFFFFFFF);
    reg_rd(1'b0, 2'h3, 32'h800037FF);
    reg_wr(1'b1, 2'h3, 32'hFFFFFFFF);
    reg_rd(1'b1, 2'h3, 32'h0033C640);
    // Lower levels must neither write nor read either register
    for (int l = 0; l < 3; l++)
    begin
      reg_wr(l[0], l[1:0], 32'h0);
      reg_rd(l[0], l[1:0], 32'h0);
    end
    reg_rd(1'b1, 2'h3, 32'h0033C640);
    reg_rd(1'b0, 2'h3, 32'h800037FF);
    $display("access level tests done");
    // Second reset in mid-run must restore the documented values
    @(posedge clk);
    rst <= 1'b1;
    // Outputs that were high must drop at once while reset stands
    #1;
    chk_out(outs, 5'h00);
    chk_out({4'h0, denied}, 5'h00);
    @(posedge clk);
    rst <= 1'b0;
    reg_rd(1'b0, 2'h3, 32'h000033FF);
    reg_rd(1'b1, 2'h3, 32'h00000000);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* mltdc_pkg.sv */
// Package with register layout and constants for the monitor trap/debug bank
// ****************************************************************************
// Summary of operation
// R1 - Coprocessor-access trap bit traps lower accesses
// R2 - Float/vector trap bit traps, resets clear
// R3 - Perfmon external access disable, overridable, resets 0
// R4 - Breakpoint external access disable, overridable, resets 0
// R5 - Secure event counting enable, resets 0
// R6 - Secure debug disable blocks secure debug
// R7 - Clear disable: user enabled, kernel conditional
// R8 - 32-bit secure privileged debug field decode
// R9 - OS debug register trap bit
// R10 - Remaining debug register trap bit
// R11 - Perfmon register trap bit
// R12 - Registers reachable only at monitor level
// R13 - Reserved bits fixed, writes ignored
// ****************************************************************************
package mltdc_pkg;
  // Privilege levels
  typedef enum logic [1:0] {
    MLTDC_USER = 2'h0,
    MLTDC_KERNEL = 2'h1,
    MLTDC_HYP = 2'h2,
    MLTDC_MONITOR = 2'h3
  } mltdc_level_t;
  // Register selects
  localparam logic MLTDC_SEL_TRAP = 1'h0;
  localparam logic MLTDC_SEL_DEBUG = 1'h1;
  // Feature trap register fields
  localparam int MLTDC_CPAC_BIT = 31;
  localparam int MLTDC_FP_BIT = 10;
  localparam logic [31:0] MLTDC_TRAP_RES1 = 32'h000033FF;
  localparam logic [31:0] MLTDC_TRAP_WMASK = 32'h80000400;
  localparam logic [31:0] MLTDC_TRAP_RESET = 32'h000033FF;
  // Debug config register fields
  localparam int MLTDC_EXT_PERFMON_ACCESS_DISABLE_BIT = 21;
  localparam int MLTDC_EXT_BREAKPOINT_ACCESS_DISABLE_BIT = 20;
  localparam int MLTDC_SECURE_EVENT_COUNT_ENABLE_BIT = 17;
  localparam int MLTDC_SDD_BIT = 16;
  localparam int MLTDC_SPD_HI = 15;
  localparam int MLTDC_SPD_LO = 14;
  localparam int MLTDC_OSDA_BIT = 10;
  localparam int MLTDC_DA_BIT = 9;
  localparam int MLTDC_PM_BIT = 6;
  localparam logic [31:0] MLTDC_DBG_WMASK = 32'h0033C640;
  // Unknown-reset bits are given zero here
  localparam logic [31:0] MLTDC_DBG_RESET = 32'h00000000;
  // Decode of the 32-bit privileged debug field
  localparam logic [1:0] MLTDC_SPD_LEGACY = 2'h0;
  localparam logic [1:0] MLTDC_SPD_DISABLE = 2'h2;
  localparam logic [1:0] MLTDC_SPD_ENABLE = 2'h3;
endpackage
